// ---- rtl/spindle_map_pkg.sv ----
// Constants shared by the spindle status output mapper and its helpers.
// Assumes a 40 MHz control clock and a 32-bit classic Wishbone register bus.
package spindle_map_pkg;
   // Terminal and selection field geometry
   localparam int         TERM_N       = 14;
   localparam int         SEL_W        = 5;
   localparam int         IDX_W        = 4;
   localparam logic [4:0] SEL_RESET    = 5'h00;
   localparam logic [4:0] SEL_MAX      = 5'h17;
   localparam logic [4:0] SEL_REACH    = 5'h03;
   localparam logic [4:0] SEL_ESTOP    = 5'h0a;
   localparam logic [4:0] SEL_CODE0    = 5'h14;
   localparam logic [4:0] SEL_CODE1    = 5'h15;
   localparam logic [4:0] SEL_CODE2    = 5'h16;
   localparam logic [4:0] SEL_CODE3    = 5'h17;

   // Register byte offsets
   localparam logic [7:0] OFF_CLAMP    = 8'h00;
   localparam logic [7:0] OFF_FLAGS    = 8'h04;
   localparam logic [7:0] OFF_IRQ_ST   = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFF_TERM     = 8'h10;
   localparam logic [7:0] OFF_SEL_BASE = 8'h40;

   // Field positions of the flag and interrupt registers
   localparam int         FLG_REACH    = 0;
   localparam int         FLG_ESTOP    = 1;
   localparam int         FLG_CODE     = 4;
   localparam int         FLG_BUSY     = 8;
   localparam int         IRQ_W        = 3;
   localparam int         IRQ_REACH    = 0;
   localparam int         IRQ_ESTOP    = 1;
   localparam int         IRQ_ALARM    = 2;

   // Values after reset
   localparam logic [15:0] CLAMP_RESET = 16'h0000;
   localparam logic [2:0]  MASK_RESET  = 3'h0;

   // Alarm codes, bit 3 most significant
   localparam logic [3:0] AL_NONE      = 4'h0;
   localparam logic [3:0] AL_OVERHEAT  = 4'h1;
   localparam logic [3:0] AL_SPEED_DEV = 4'h2;
   localparam logic [3:0] AL_OVERSPEED = 4'h3;
   localparam logic [3:0] AL_OVERCURR  = 4'h4;
   localparam logic [3:0] AL_OVERLOAD  = 4'h5;
   localparam logic [3:0] AL_ESTOP     = 4'h6;
   localparam logic [3:0] AL_DRIVE_OTH = 4'h7;
   localparam logic [3:0] AL_PWR_MOD   = 4'h8;
   localparam logic [3:0] AL_PHASE     = 4'h9;
   localparam logic [3:0] AL_GROUND    = 4'ha;
   localparam logic [3:0] AL_MAIN_CIRC = 4'hb;
   localparam logic [3:0] AL_EXT_ESTOP = 4'hc;
   localparam logic [3:0] AL_OVERVOLT  = 4'hd;
   localparam logic [3:0] AL_NO_SIGNAL = 4'he;
   localparam logic [3:0] AL_OTHER     = 4'hf;
   localparam logic [3:0] STARTUP_CODE = 4'hf;

   // Power-up settling time
   localparam int         CLK_HZ         = 40000000;
   localparam int         POWERUP_MS     = 1000;
   localparam int         POWERUP_CYCLES = CLK_HZ / 1000 * POWERUP_MS;
   localparam int         CNT_W          = 26;
endpackage : spindle_map_pkg

// ---- rtl/sel_bank_if.sv ----
// Carrier between the mapper and its selection register bank.
// Assumes the mapper drives the write and read address side.
`timescale 1ns/1ps
interface sel_bank_if;
   logic                                    we;
   logic [spindle_map_pkg::IDX_W-1:0]        waddr;
   logic [spindle_map_pkg::SEL_W-1:0]        wdata;
   logic [spindle_map_pkg::IDX_W-1:0]        raddr;
   logic [spindle_map_pkg::SEL_W-1:0]        rdata;
   logic [spindle_map_pkg::TERM_N-1:0][spindle_map_pkg::SEL_W-1:0] sel_all;

   modport bank (input we, waddr, wdata, raddr, output rdata, sel_all);
   modport user (output we, waddr, wdata, raddr, input rdata, sel_all);
endinterface : sel_bank_if

// ---- rtl/sel_bank.sv ----
// Bank of terminal selection codes with a registered read port.
// Assumes one write per cycle from the mapper's bus logic.
`timescale 1ns/1ps
module sel_bank
(
   input  wire logic  clk,
   input  wire logic  rst_n,
   sel_bank_if.bank   sb
);
   typedef struct packed {
      logic [spindle_map_pkg::TERM_N-1:0][spindle_map_pkg::SEL_W-1:0] sel;
      logic [spindle_map_pkg::SEL_W-1:0]                             rdata;
   } bank_s;

   bank_s q;
   bank_s d;

   // Store legal codes only, read out through a register
   always_comb
   begin
      d = q;
      if (sb.we && sb.wdata <= spindle_map_pkg::SEL_MAX &&
          int'(sb.waddr) < spindle_map_pkg::TERM_N)
      begin
         d.sel[sb.waddr] = sb.wdata;
      end
      if (int'(sb.raddr) < spindle_map_pkg::TERM_N)
      begin
         d.rdata = q.sel[sb.raddr];
      end
      else
      begin
         d.rdata = '0;
      end
   end

   // State register, every code clears to zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign sb.rdata   = q.rdata;
   assign sb.sel_all = q.sel;

   // Out of range codes leave the entry untouched
   sel_reject_a: assert property (@(posedge clk) disable iff (!rst_n)
      (sb.we && sb.wdata > spindle_map_pkg::SEL_MAX &&
       int'(sb.waddr) < spindle_map_pkg::TERM_N)
      |=> (sb.sel_all[$past(sb.waddr)] == $past(sb.sel_all[sb.waddr])))
      else $error("selection code above range was stored");
endmodule : sel_bank

// ---- rtl/powerup_timer.sv ----
// Power-up settling timer, busy from reset until the interval ends.
// Assumes the reset is the power-on reset of the drive.
`timescale 1ns/1ps
module powerup_timer #(
   parameter int CYCLES = spindle_map_pkg::POWERUP_CYCLES
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   output logic      busy
);
   localparam int W = spindle_map_pkg::CNT_W;
   typedef logic [W-1:0] cnt_t;

   typedef struct packed {
      cnt_t cnt;
      logic busy;
   } tmr_s;

   tmr_s q;
   tmr_s d;

   // Count once through the interval, then stay idle
   always_comb
   begin
      d = q;
      if (q.busy)
      begin
         if (q.cnt == cnt_t'(CYCLES - 1))
         begin
            d.busy = 1'b0;
         end
         else
         begin
            d.cnt = q.cnt + cnt_t'(1);
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '{cnt: '0, busy: 1'b1};
      end
      else
      begin
         q <= d;
      end
   end

   assign busy = q.busy;

   // Interval ends exactly after the programmed count
   busy_end_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(q.busy) |-> ($past(q.cnt) == cnt_t'(CYCLES - 1)))
      else $error("power-up interval ended at wrong count");
endmodule : powerup_timer

// ---- rtl/spindle_status_output_mapper.sv ----
// Spindle status flag generation and routing onto fourteen terminals.
// Assumes synchronous inputs from the drive control and a Wishbone master.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Torque reached when started and command equals clamp
// - Code 3 routes torque reached flag
// - Estop flag follows the emergency stop input
// - Code 10 routes estop active flag
// - Fourteen selections, range 0 to 23, reset 0
// - Alarm shown as four-bit code, bit3 MSB
// - Codes 1-7 encode the drive-side alarm causes
// - Codes 8-15 encode the power-side alarm causes
// - Startup code allowed one second, then settled
// - Codes 20-23 route alarm bits 0-3
module spindle_status_output_mapper #(
   parameter int POWERUP_CYCLES = spindle_map_pkg::POWERUP_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        start_cmd,
   input  wire logic [15:0] torque_cmd,
   input  wire logic        estop_in,
   input  wire logic [14:0] alarm_src,
   output logic      [13:0] term_out,
   output logic             irq_o
);
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_FETCH,
      BUS_ANSWER
   } bus_state_e;

   typedef struct packed {
      bus_state_e   st;
      logic         ack;
      logic [31:0]  dat;
      logic [15:0]  clamp;
      logic         reach;
      logic         estop;
      logic [3:0]   code;
      logic [2:0]   irq_st;
      logic [2:0]   irq_mask;
      logic         irq;
      logic [13:0]  term;
   } map_s;

   map_s q;
   map_s d;
   logic busy;

   sel_bank_if sb ();

   // Selection register bank
   sel_bank u_bank
   (
      .clk   (clk),
      .rst_n (rst_n),
      .sb    (sb)
   );

   // Power-up settling timer
   powerup_timer #(
      .CYCLES (POWERUP_CYCLES)
   ) u_timer
   (
      .clk   (clk),
      .rst_n (rst_n),
      .busy  (busy)
   );

   // True when the address falls on a selection register
   function automatic logic sel_hit(input logic [7:0] adr);
      logic [3:0] idx;
      idx = adr[5:2];
      return (adr[7:6] == spindle_map_pkg::OFF_SEL_BASE[7:6]) &&
             (int'(idx) < spindle_map_pkg::TERM_N);
   endfunction : sel_hit

   // Priority encoder, lowest numbered active cause wins
   function automatic logic [3:0] encode(input logic [14:0] src);
      logic [3:0] c;
      c = spindle_map_pkg::AL_NONE;
      for (int k = 14; k >= 0; k--)
      begin
         if (src[k])
         begin
            c = 4'(k + 1);
         end
      end
      return c;
   endfunction : encode

   // Value a terminal shows for its selection code
   function automatic logic route(input logic [4:0] sel,
                                  input logic       reach,
                                  input logic       estop,
                                  input logic [3:0] code);
      logic r;
      r = 1'b0;
      case (sel)
         spindle_map_pkg::SEL_REACH: r = reach;
         spindle_map_pkg::SEL_ESTOP: r = estop;
         spindle_map_pkg::SEL_CODE0: r = code[0];
         spindle_map_pkg::SEL_CODE1: r = code[1];
         spindle_map_pkg::SEL_CODE2: r = code[2];
         spindle_map_pkg::SEL_CODE3: r = code[3];
         default:                    r = 1'b0;
      endcase
      return r;
   endfunction : route

   // Bank ports follow the held bus request
   assign sb.raddr = wb_adr_i[5:2];
   assign sb.waddr = wb_adr_i[5:2];
   assign sb.wdata = wb_dat_i[4:0];
   assign sb.we    = (q.st == BUS_FETCH) && wb_we_i && wb_sel_i[0] &&
                     sel_hit(wb_adr_i);

   // Flags, events, routing and the bus slave
   always_comb
   begin
      logic [2:0]  ev;
      logic [2:0]  clr;
      logic [31:0] rd;
      logic        wr;
      ev  = '0;
      clr = '0;
      rd  = '0;
      wr  = 1'b0;
      d   = q;

      // Status flags
      d.reach = start_cmd && (torque_cmd == q.clamp);
      d.estop = estop_in;
      if (busy)
      begin
         d.code = spindle_map_pkg::STARTUP_CODE;
      end
      else
      begin
         d.code = encode(alarm_src);
      end

      // Events that set sticky interrupt bits
      ev[spindle_map_pkg::IRQ_REACH] = d.reach & ~q.reach;
      ev[spindle_map_pkg::IRQ_ESTOP] = d.estop & ~q.estop;
      ev[spindle_map_pkg::IRQ_ALARM] = !busy && (d.code != q.code) &&
                                       (d.code != spindle_map_pkg::AL_NONE);

      // Terminal routing, alarm bits assumed all assigned
      for (int i = 0; i < spindle_map_pkg::TERM_N; i++)
      begin
         d.term[i] = route(sb.sel_all[i], q.reach, q.estop, q.code);
      end

      // Read data source
      if (sel_hit(wb_adr_i))
      begin
         rd = {27'h0000000, sb.rdata};
      end
      else
      begin
         case (wb_adr_i)
            spindle_map_pkg::OFF_CLAMP:    rd = {16'h0000, q.clamp};
            spindle_map_pkg::OFF_FLAGS:
            begin
               rd[spindle_map_pkg::FLG_REACH] = q.reach;
               rd[spindle_map_pkg::FLG_ESTOP] = q.estop;
               rd[spindle_map_pkg::FLG_CODE +: 4] = q.code;
               rd[spindle_map_pkg::FLG_BUSY]  = busy;
            end
            spindle_map_pkg::OFF_IRQ_ST:   rd = {29'h00000000, q.irq_st};
            spindle_map_pkg::OFF_IRQ_MASK: rd = {29'h00000000, q.irq_mask};
            spindle_map_pkg::OFF_TERM:     rd = {18'h00000, q.term};
            default:                       rd = '0;
         endcase
      end

      // Bus sequence: take, fetch, answer
      case (q.st)
         BUS_IDLE:
         begin
            d.ack = 1'b0;
            if (wb_cyc_i && wb_stb_i)
            begin
               d.st = BUS_FETCH;
            end
         end
         BUS_FETCH:
         begin
            d.st  = BUS_ANSWER;
            d.ack = 1'b1;
            d.dat = wb_we_i ? 32'h00000000 : rd;
            wr    = wb_we_i;
         end
         BUS_ANSWER:
         begin
            d.st  = BUS_IDLE;
            d.ack = 1'b0;
         end
         default:
         begin
            d.st  = BUS_IDLE;
            d.ack = 1'b0;
         end
      endcase

      // Register writes, byte lanes honoured
      if (wr)
      begin
         case (wb_adr_i)
            spindle_map_pkg::OFF_CLAMP:
            begin
               if (wb_sel_i[0])
               begin
                  d.clamp[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1])
               begin
                  d.clamp[15:8] = wb_dat_i[15:8];
               end
            end
            spindle_map_pkg::OFF_IRQ_ST:
            begin
               if (wb_sel_i[0])
               begin
                  clr = wb_dat_i[2:0];
               end
            end
            spindle_map_pkg::OFF_IRQ_MASK:
            begin
               if (wb_sel_i[0])
               begin
                  d.irq_mask = wb_dat_i[2:0];
               end
            end
            default:
            begin
               clr = '0;
            end
         endcase
      end

      // Sticky status, a new event beats a clear
      d.irq_st = (q.irq_st & ~clr) | ev;
      d.irq    = |(q.irq_st & q.irq_mask);
   end

   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q          <= '0;
         q.st       <= BUS_IDLE;
         q.clamp    <= spindle_map_pkg::CLAMP_RESET;
         q.irq_mask <= spindle_map_pkg::MASK_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign term_out = q.term;
   assign irq_o    = q.irq;

   // Torque reached follows start and clamp equality
   reach_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      q.reach == $past(start_cmd && (torque_cmd == q.clamp)))
      else $error("torque reached flag wrong");

   // Estop flag tracks its input one cycle later
   estop_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(estop_in) |-> q.estop ##1 (q.estop == $past(estop_in)))
      else $error("estop flag does not follow input");

   // Code encoding for single causes, then the lowest of two causes wins
   code_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!busy && alarm_src == 15'h0020) |=> (q.code == 4'h6))
      else $error("emergency stop cause gives wrong code");

   code_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!busy && alarm_src == 15'h0800) |=> (q.code == 4'hc))
      else $error("external stop cause gives wrong code");

   code_order_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!busy && alarm_src == 15'h0006) |=> (q.code == 4'h2))
      else $error("lowest active cause does not win");

   // After the startup window no fault means no alarm
   settle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!busy && alarm_src == 15'h0000) |=> (q.code == 4'h0))
      else $error("alarm code not settled after startup");

   // Per terminal routing checks
   for (genvar g = 0; g < spindle_map_pkg::TERM_N; g++)
   begin : g_term_chk
      term_reach_a: assert property (@(posedge clk)
         disable iff (!rst_n)
         (sb.sel_all[g] == 5'h03) |=> (q.term[g] == $past(q.reach)))
         else $error("terminal does not show torque reached");

      term_estop_a: assert property (@(posedge clk)
         disable iff (!rst_n)
         (sb.sel_all[g] == 5'h0a) |=> (q.term[g] == $past(q.estop)))
         else $error("terminal does not show estop flag");

      term_alarm_a: assert property (@(posedge clk)
         disable iff (!rst_n)
         (sb.sel_all[g] >= 5'h14 && sb.sel_all[g] <= 5'h17) |=>
         (q.term[g] == $past(q.code[sb.sel_all[g][1:0]])))
         else $error("terminal shows wrong alarm bit");

      term_idle_a: assert property (@(posedge clk)
         disable iff (!rst_n)
         (sb.sel_all[g] != 5'h03 && sb.sel_all[g] != 5'h0a &&
          sb.sel_all[g] < 5'h14) |=> !q.term[g])
         else $error("unassigned terminal is active");
   end

   // Interrupt line follows unmasked sticky bits
   irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq_o == $past(|(q.irq_st & q.irq_mask)))
      else $error("interrupt line wrong");

   // Acknowledge lasts exactly one cycle
   ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(wb_ack_o) |=> !wb_ack_o ##1 !wb_ack_o)
      else $error("acknowledge longer than one cycle");
endmodule : spindle_status_output_mapper

// ---- test/plc_input_model.sv ----
// Model of the controller inputs that read the mapper's terminals.
// Assumes the four alarm code terminals sit side by side from T_AL0.
`timescale 1ns/1ps
module plc_input_model #(
   parameter int T_REACH = 0,
   parameter int T_ESTOP = 1,
   parameter int T_AL0   = 2
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [13:0] term_out,
   output logic             reach_seen,
   output logic             estop_seen,
   output logic      [3:0]  code_seen
);
   // Input stage of the controller: one register per terminal
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reach_seen <= 1'b0;
         estop_seen <= 1'b0;
         code_seen  <= 4'h0;
      end
      else
      begin
         reach_seen <= term_out[T_REACH];
         estop_seen <= term_out[T_ESTOP];
         code_seen  <= term_out[T_AL0+3 -: 4]; // Whole code
      end
   end
endmodule : plc_input_model

// ---- test/spindle_status_output_mapper_tb_top.sv ----
// Self-checking bench of the spindle status output mapper.
// Assumes classic Wishbone register access and a short power-up window.
`timescale 1ns/1ps
module spindle_status_output_mapper_tb_top;
   localparam int PU = 20;
   localparam logic [7:0] SEL0 = spindle_map_pkg::OFF_SEL_BASE;
   logic        clk;
   logic        rst_n;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [31:0] wdat;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        start_cmd;
   logic [15:0] torque_cmd;
   logic        estop_in;
   logic [14:0] alarm_src;
   logic [13:0] term_out;
   logic        irq_o;
   logic        reach_seen;
   logic        estop_seen;
   logic [3:0]  code_seen;
   logic [31:0] rd;
   int          n_fail;
   int          cmp_count;
   // Terminal map: torque, estop, alarm bits 0..3, then unused codes
   logic [4:0]  map_t [14] = '{5'h03, 5'h0a, 5'h14, 5'h15, 5'h16, 5'h17,
                               5'h09, 5'h0f, 5'h01, 5'h00, 5'h00, 5'h00,
                               5'h00, 5'h00};

   spindle_status_output_mapper #(.POWERUP_CYCLES(PU)) dut (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_cmd(start_cmd),
      .torque_cmd(torque_cmd), .estop_in(estop_in), .alarm_src(alarm_src),
      .term_out(term_out), .irq_o(irq_o));

   plc_input_model #(.T_REACH(0), .T_ESTOP(1), .T_AL0(2)) plc (
      .clk(clk), .rst_n(rst_n), .term_out(term_out), .reach_seen(reach_seen),
      .estop_seen(estop_seen), .code_seen(code_seen));

   task automatic stop_test;
      if (n_fail == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic [13:0] got, input logic [13:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t pin got %h exp %h", $time, got, exp);
      end
   endtask : chk_pin

   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (wb_ack_o !== 1'b1)
      begin
         n_fail++;
         stop_test();
      end
   endtask : wb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk_reg(rd, exp);
   endtask : rdchk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // Clock generator
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Run-length guard
   initial
   begin
      repeat (100000) @(posedge clk);
      n_fail++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
      wdat = 32'h0; start_cmd = 1'b0; torque_cmd = 16'h0000;
      estop_in = 1'b0; alarm_src = 15'h0000; n_fail = 0; cmp_count = 0;
      tick(3);
      rst_n <= 1'b1;
      // Power-up window, reset values, unmapped place
      rdchk(spindle_map_pkg::OFF_FLAGS, 32'h0000_01f0);
      for (int i = 0; i < 14; i++)
         rdchk(spindle_map_pkg::OFF_SEL_BASE + 8'(4 * i), 32'h0);
      chk_pin(term_out, 14'h0000);
      rdchk(spindle_map_pkg::OFF_FLAGS, 32'h0);
      rdchk(8'h30, 32'h0);
      rdchk(spindle_map_pkg::OFF_IRQ_MASK, 32'h0);
      // Out-of-range code dropped, whole map written and read back
      wb(1'b1, spindle_map_pkg::OFF_SEL_BASE, 32'h18);
      rdchk(spindle_map_pkg::OFF_SEL_BASE, 32'h0);
      for (int i = 0; i < 14; i++)
         wb(1'b1, SEL0 + 8'(4 * i), 32'(map_t[i]));
      for (int i = 0; i < 14; i++)
         rdchk(SEL0 + 8'(4 * i), 32'(map_t[i]));
      // Emergency stop flag, its event, mask and clear
      @(posedge clk);
      estop_in <= 1'b1;
      tick(5);
      chk_pin(term_out, 14'h0002);
      chk_pin({13'h0, estop_seen}, 14'h1);
      rdchk(spindle_map_pkg::OFF_FLAGS, 32'h2);
      rdchk(spindle_map_pkg::OFF_IRQ_ST, 32'h2);
      chk_pin({13'h0, irq_o}, 14'h0);
      wb(1'b1, spindle_map_pkg::OFF_IRQ_MASK, 32'h2);
      tick(2);
      chk_pin({13'h0, irq_o}, 14'h1);
      wb(1'b1, spindle_map_pkg::OFF_IRQ_ST, 32'h2);
      tick(2);
      chk_pin({13'h0, irq_o}, 14'h0);
      @(posedge clk);
      estop_in <= 1'b0;
      tick(4);
      chk_pin(term_out, 14'h0000);
      // Torque reach: one below clamp, equal, then start removed
      wb(1'b1, spindle_map_pkg::OFF_CLAMP, 32'h1234);
      rdchk(spindle_map_pkg::OFF_CLAMP, 32'h0000_1234);
      @(posedge clk);
      start_cmd  <= 1'b1;
      torque_cmd <= 16'h1233;
      tick(4);
      chk_pin(term_out, 14'h0000);
      torque_cmd <= 16'h1234;
      tick(5);
      chk_pin(term_out, 14'h0001);
      chk_pin({13'h0, reach_seen}, 14'h1);
      rdchk(spindle_map_pkg::OFF_TERM, 32'h1);
      @(posedge clk);
      start_cmd <= 1'b0;
      tick(4);
      chk_pin(term_out, 14'h0000);
      // Every alarm code on the four code terminals
      for (int k = 1; k < 16; k++)
      begin
         alarm_src <= 15'h1 << (k - 1);
         tick(5);
         chk_pin(term_out, 14'(k << 2));
         chk_pin({10'h0, code_seen}, 14'(k));
      end
      alarm_src <= 15'h0006;
      tick(5);
      chk_pin({10'h0, code_seen}, 14'h2);
      alarm_src <= 15'h0000;
      tick(5);
      chk_pin(term_out, 14'h0000);
      // Torque and alarm events pending, alarm event unmasked
      rdchk(spindle_map_pkg::OFF_IRQ_ST, 32'h5);
      wb(1'b1, spindle_map_pkg::OFF_IRQ_MASK, 32'h4);
      tick(2);
      chk_pin({13'h0, irq_o}, 14'h1);
      wb(1'b1, spindle_map_pkg::OFF_IRQ_ST, 32'h5);
      tick(2);
      chk_pin({13'h0, irq_o}, 14'h0);
      stop_test();
   end
endmodule : spindle_status_output_mapper_tb_top
